// File: cpu_state_regs.sv
// CPU programmer state: stack pointer, program counter, condition codes
// Driven by the core sequencer strobes; APB slave for register access
//
// What this block does
// - Stack pointer held at 00FF while in reset.
// - Reset-stack-low op sets low byte FF, high byte kept.
// - Push decrements stack pointer by one, pull increments by one.
// - Stack-relative address is stack pointer plus 8- or 16-bit offset.
// - Program counter increments per fetch; jumps and interrupts load targets.
// - After reset program counter loads from vector at FFFE/FFFF.
// - Condition code bits 6 and 5 always read one.
// - Overflow flag follows two's complement overflow; feeds signed compare.
// - Half carry from bit 3 to 4; decimal adjust uses it with carry.
// - Mask bit set blocks maskable interrupts; clear lets them in.
// - Interrupt entry stacks registers, then sets mask, then fetches vector.
// - Interrupt stacking excludes index high byte; only explicit ops move it.
// - With several requests pending, highest priority is serviced first.
// - Return from interrupt restores condition codes including mask.
// - Reset sets mask; clear-mask op, wait, stop, return from interrupt and APB writes can clear it.
// - Negative flag copies result bit 7.
// - Zero flag set when result is 00.
// - Carry flag from bit 7 carry or borrow, shifts and bit tests.
// - Wait clears mask, stops clock; interrupt wakeup stacks registers and sets mask.
// - Stop clears mask, stops clock; restart after stabilization delay.
// - Break loads software-interrupt op and vector FFFC or FEFC.
// - Break starts at instruction end; return ends it once request drops.
`timescale 1ns/1ps
module cpu_state_regs (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PUSH_EN,
  input  wire logic        PULL_EN,
  input  wire logic        RSP_EN,
  input  wire logic        FETCH_EN,
  input  wire logic        JUMP_EN,
  input  wire logic [15:0] JUMP_ADDR,
  input  wire logic [15:0] SP_OFS,
  input  wire logic        SP_OFS_WIDE,
  input  wire logic [7:0]  ALU_RESULT,
  input  wire logic        ALU_CARRY,
  input  wire logic        ALU_OVF,
  input  wire logic        ALU_HALF,
  input  wire logic [4:0]  FLAG_WE,
  input  wire logic [7:0]  ACC,
  input  wire logic        CLI_EN,
  input  wire logic        RTI_CCR_EN,
  input  wire logic [7:0]  PULL_DATA,
  input  wire logic        INSTR_LAST,
  input  wire logic [3:0]  IRQ_REQ,
  input  wire logic        WAIT_EN,
  input  wire logic        STOP_EN,
  input  wire logic        BRK_REQ,
  input  wire logic        MONITOR,
  input  wire logic        VEC_VALID,
  input  wire logic [15:0] VEC_DATA,
  output logic      [15:0] SP,
  output logic      [15:0] PC,
  output logic      [7:0]  CONDITION_CODE_REG,
  output logic      [15:0] EA,
  output logic      [15:0] VEC_ADDR,
  output logic             VEC_RD,
  output logic      [1:0]  IRQ_ID,
  output logic             SWI_LOAD,
  output logic             BRK_ACTIVE,
  output logic             CPU_CLK_EN,
  output logic             SIGNED_LT,
  output logic      [7:0]  DAA_ADJ
);
  import cpu_state_pkg::*;

  regs_t st_r;
  regs_t st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Lowest index wins
  function automatic logic [1:0] irq_pick(input logic [3:0] req);
    logic [1:0] id;
    id = 2'h3;
    for (int k = 3; k >= 0; k--) begin
      if (req[k]) begin
        id = 2'(k);
      end
    end
    return id;
  endfunction

  function automatic logic [15:0] irq_vec(input logic [1:0] id);
    return VEC_IRQ_TOP - {13'h0000, id, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic       apb_acc;
  logic [7:0] alu_flags;

  always_comb begin
    st_nxt = st_r;
    st_nxt.swi_ld = 1'b0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    apb_acc = PSEL && PENABLE && !st_r.pready;
    alu_flags = st_r.condition_code_reg;
    alu_flags[CCR_V] = ALU_OVF;
    alu_flags[CCR_H] = ALU_HALF;
    alu_flags[CCR_N] = ALU_RESULT[7];
    alu_flags[CCR_Z] = (ALU_RESULT == 8'h00);
    alu_flags[CCR_C] = ALU_CARRY;
    st_nxt.ea = st_r.sp + (SP_OFS_WIDE ? SP_OFS
                                       : {8'h00, SP_OFS[7:0]});
    if (st_r.state == ST_RUN && BRK_REQ && !INSTR_LAST && !st_r.brk_act) begin
      st_nxt.brk_pend = 1'b1;
    end
    unique case (st_r.state)
      ST_VECTOR: begin
        st_nxt.vec_rd = 1'b1;
        if (VEC_VALID && st_r.vec_rd) begin
          st_nxt.pc = VEC_DATA;
          st_nxt.vec_rd = 1'b0;
          st_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (PUSH_EN) begin
          st_nxt.sp = st_r.sp - 16'h0001;
        end else if (PULL_EN) begin
          st_nxt.sp = st_r.sp + 16'h0001;
        end
        if (RSP_EN) begin
          st_nxt.sp[7:0] = SP_LOW_RST;
        end
        if (JUMP_EN) begin
          st_nxt.pc = JUMP_ADDR;
        end else if (FETCH_EN) begin
          st_nxt.pc = st_r.pc + 16'h0001;
        end
        for (int f = 0; f < 5; f++) begin
          if (FLAG_WE[f]) begin
            st_nxt.condition_code_reg[(f == FW_V) ? CCR_V : f + ((f >= FW_H) ? 1 : 0)]
              = alu_flags[(f == FW_V) ? CCR_V : f + ((f >= FW_H) ? 1 : 0)];
          end
        end
        if (CLI_EN) begin
          st_nxt.condition_code_reg[CCR_I] = 1'b0;
        end
        if (RTI_CCR_EN) begin
          st_nxt.condition_code_reg = PULL_DATA;
          if (st_r.brk_act && !BRK_REQ) begin
            st_nxt.brk_act = 1'b0;
          end
        end
        if (INSTR_LAST && !st_r.brk_act && (st_r.brk_pend || BRK_REQ)) begin
          st_nxt.swi_ld = 1'b1;
          st_nxt.brk_act = 1'b1;
          st_nxt.brk_pend = 1'b0;
          st_nxt.vec = MONITOR ? VEC_BRK_MON : VEC_BRK;
          st_nxt.cnt = 13'h0000;
          st_nxt.state = ST_STACKING;
        end else if (INSTR_LAST && |IRQ_REQ && !st_r.condition_code_reg[CCR_I]) begin
          st_nxt.irq_id = irq_pick(IRQ_REQ);
          st_nxt.vec = irq_vec(irq_pick(IRQ_REQ));
          st_nxt.cnt = 13'h0000;
          st_nxt.state = ST_STACKING;
        end else if (WAIT_EN) begin
          st_nxt.condition_code_reg[CCR_I] = 1'b0;
          st_nxt.clk_en = 1'b0;
          st_nxt.state = ST_WAITING;
        end else if (STOP_EN) begin
          st_nxt.condition_code_reg[CCR_I] = 1'b0;
          st_nxt.clk_en = 1'b0;
          st_nxt.state = ST_STOPPED;
        end
      end
      ST_STACKING: begin
        // Five bytes: PC low, PC high, X, A, CONDITION_CODE_REG; H stays off the stack
        st_nxt.sp = st_r.sp - 16'h0001;
        st_nxt.cnt = st_r.cnt + 13'h0001;
        if (st_r.cnt == STACK_BYTES - 13'h0001) begin
          st_nxt.state = ST_SET_MASK;
        end
      end
      ST_SET_MASK: begin
        st_nxt.condition_code_reg[CCR_I] = 1'b1;
        st_nxt.vec_rd = 1'b0;
        st_nxt.state = ST_VECTOR;
      end
      ST_WAITING: begin
        if (|IRQ_REQ) begin
          st_nxt.clk_en = 1'b1;
          st_nxt.irq_id = irq_pick(IRQ_REQ);
          st_nxt.vec = irq_vec(irq_pick(IRQ_REQ));
          st_nxt.cnt = 13'h0000;
          st_nxt.state = ST_STACKING;
        end
      end
      ST_STOPPED: begin
        if (|IRQ_REQ) begin
          st_nxt.irq_id = irq_pick(IRQ_REQ);
          st_nxt.vec = irq_vec(irq_pick(IRQ_REQ));
          st_nxt.cnt = 13'h0000;
          st_nxt.state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        st_nxt.cnt = st_r.cnt + 13'h0001;
        if (st_r.cnt == STAB_CYCLES - 13'h0001) begin
          st_nxt.clk_en = 1'b1;
          st_nxt.cnt = 13'h0000;
          st_nxt.state = ST_STACKING;
        end
      end
    endcase
    // APB slave, one wait state
    if (apb_acc) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      unique case (PADDR)
        OFS_SP: begin
          st_nxt.prdata = {16'h0000, st_r.sp};
          if (PWRITE) begin
            st_nxt.sp = PWDATA[15:0];
          end
        end
        OFS_PC: begin
          st_nxt.prdata = {16'h0000, st_r.pc};
          if (PWRITE) begin
            st_nxt.pc = PWDATA[15:0];
          end
        end
        OFS_CCR: begin
          st_nxt.prdata = {24'h000000, st_r.condition_code_reg};
          if (PWRITE) begin
            st_nxt.condition_code_reg = PWDATA[7:0];
          end
        end
        OFS_STAT: begin
          st_nxt.prdata = {26'h0000000, st_r.brk_act, st_r.clk_en,
                           1'b0, st_r.state};
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    st_nxt.condition_code_reg = st_nxt.condition_code_reg | CCR_ONES;
    st_nxt.sgn_lt = st_nxt.condition_code_reg[CCR_N] ^ st_nxt.condition_code_reg[CCR_V];
    st_nxt.daa_adj = {((st_nxt.condition_code_reg[CCR_C] || ACC > 8'h99) ? 4'h6 : 4'h0),
                      ((st_nxt.condition_code_reg[CCR_H] || ACC[3:0] > 4'h9)
                       ? 4'h6 : 4'h0)};
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '{state: ST_VECTOR, sp: SP_RST, pc: 16'h0000,
                condition_code_reg: CCR_RST, cnt: 13'h0000, ea: 16'h0000,
                vec: VEC_RESET, vec_rd: 1'b0, irq_id: 2'h0,
                swi_ld: 1'b0, brk_act: 1'b0, brk_pend: 1'b0,
                clk_en: 1'b1, sgn_lt: 1'b0, daa_adj: 8'h00,
                prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA     = st_r.prdata;
  assign PREADY     = st_r.pready;
  assign PSLVERR    = st_r.pslverr;
  assign SP         = st_r.sp;
  assign PC         = st_r.pc;
  assign CONDITION_CODE_REG        = st_r.condition_code_reg;
  assign EA         = st_r.ea;
  assign VEC_ADDR   = st_r.vec;
  assign VEC_RD     = st_r.vec_rd;
  assign IRQ_ID     = st_r.irq_id;
  assign SWI_LOAD   = st_r.swi_ld;
  assign BRK_ACTIVE = st_r.brk_act;
  assign CPU_CLK_EN = st_r.clk_en;
  assign SIGNED_LT  = st_r.sgn_lt;
  assign DAA_ADJ    = st_r.daa_adj;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic quiet_run;
  assign quiet_run = st_r.state == ST_RUN && !apb_acc && !INSTR_LAST
                     && !WAIT_EN && !STOP_EN && !RTI_CCR_EN && !CLI_EN;

  sequence stack_phase;
    (st_r.state == ST_STACKING) [*5];
  endsequence
  sequence mask_then_vec;
    (st_r.state == ST_SET_MASK) ##1 (st_r.state == ST_VECTOR
      && st_r.condition_code_reg[CCR_I]);
  endsequence

  a_sp_reset: assert property (@(posedge CLK)
    RST |=> st_r.sp == SP_RST && st_r.condition_code_reg[CCR_I])
    else $error("reset did not preset stack pointer and mask");
  a_rsp_low: assert property (@(posedge CLK) disable iff (RST)
    quiet_run && RSP_EN |=> st_r.sp[7:0] == 8'hFF
      && st_r.sp[15:8] == $past(st_r.sp[15:8]))
    else $error("reset-stack-low op wrong");
  a_push_dec: assert property (@(posedge CLK) disable iff (RST)
    quiet_run && PUSH_EN && !RSP_EN
      |=> st_r.sp == $past(st_r.sp) - 16'h0001)
    else $error("push did not decrement stack pointer");
  a_pc_fetch: assert property (@(posedge CLK) disable iff (RST)
    quiet_run && FETCH_EN && !JUMP_EN
      |=> st_r.pc == $past(st_r.pc) + 16'h0001)
    else $error("fetch did not advance program counter");
  a_ccr_ones: assert property (@(posedge CLK) disable iff (RST)
    ##1 st_r.condition_code_reg[6:5] == 2'b11)
    else $error("fixed condition code bits not one");
  a_mask_block: assert property (@(posedge CLK) disable iff (RST)
    st_r.state == ST_RUN && st_r.condition_code_reg[CCR_I] && !BRK_REQ && !st_r.brk_pend
      |=> st_r.state != ST_STACKING)
    else $error("masked interrupt accepted");
  a_irq_order: assert property (@(posedge CLK) disable iff (RST)
    st_r.state == ST_RUN && st_nxt.state == ST_STACKING
      |=> stack_phase ##1 mask_then_vec)
    else $error("interrupt entry order wrong");
  a_flag_keep: assert property (@(posedge CLK) disable iff (RST)
    quiet_run && FLAG_WE == 5'h00 |=> st_r.condition_code_reg == $past(st_r.condition_code_reg))
    else $error("unaffected flags changed");
  a_zero_flag: assert property (@(posedge CLK) disable iff (RST)
    quiet_run && FLAG_WE[FW_Z]
      |=> st_r.condition_code_reg[CCR_Z] == ($past(ALU_RESULT) == 8'h00))
    else $error("zero flag wrong");
  a_wait_mask: assert property (@(posedge CLK) disable iff (RST)
    st_r.state == ST_RUN && st_nxt.state == ST_WAITING
      |=> !st_r.condition_code_reg[CCR_I] && !st_r.clk_en)
    else $error("wait entry did not clear mask or stop clock");
  a_brk_vec: assert property (@(posedge CLK) disable iff (RST)
    $rose(st_r.swi_ld) |-> st_r.vec == ($past(MONITOR) ? VEC_BRK_MON : VEC_BRK))
    else $error("break vector wrong");

endmodule

// File: cpu_state_pkg.sv
// Constants and types for the CPU state register block
// Assumes a 10 MHz single clock and an APB register bus
package cpu_state_pkg;

  // APB register byte offsets
  localparam logic [7:0]  OFS_SP     = 8'h00;
  localparam logic [7:0]  OFS_PC     = 8'h04;
  localparam logic [7:0]  OFS_CCR    = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h0C;

  // Reset values
  localparam logic [15:0] SP_RST     = 16'h00FF;
  localparam logic [7:0]  SP_LOW_RST = 8'hFF;
  localparam logic [7:0]  CCR_RST    = 8'h68;

  // Condition code field positions
  localparam int          CCR_V      = 7;
  localparam int          CCR_H      = 4;
  localparam int          CCR_I      = 3;
  localparam int          CCR_N      = 2;
  localparam int          CCR_Z      = 1;
  localparam int          CCR_C      = 0;
  localparam logic [7:0]  CCR_ONES   = 8'h60;

  // Flag write-enable positions
  localparam int          FW_V       = 4;
  localparam int          FW_H       = 3;
  localparam int          FW_N       = 2;
  localparam int          FW_Z       = 1;
  localparam int          FW_C       = 0;

  // Vector addresses
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [15:0] VEC_BRK    = 16'hFFFC;
  localparam logic [15:0] VEC_BRK_MON = 16'hFEFC;
  localparam logic [15:0] VEC_IRQ_TOP = 16'hFFFA;

  // Sequencing counts
  localparam logic [12:0] STACK_BYTES = 13'h0005;
  localparam logic [12:0] STAB_CYCLES = 13'h1000;

  typedef enum logic [2:0] {
    ST_VECTOR,
    ST_RUN,
    ST_STACKING,
    ST_SET_MASK,
    ST_WAITING,
    ST_STOPPED,
    ST_RECOVER
  } cpu_state_t;

  typedef struct packed {
    cpu_state_t  state;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  condition_code_reg;
    logic [12:0] cnt;
    logic [15:0] ea;
    logic [15:0] vec;
    logic        vec_rd;
    logic [1:0]  irq_id;
    logic        swi_ld;
    logic        brk_act;
    logic        brk_pend;
    logic        clk_en;
    logic        sgn_lt;
    logic [7:0]  daa_adj;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_t;

endpackage

// File: testbench.sv
// Self-checking bench for the CPU state register block
// Assumes cpu_state_pkg and cpu_state_regs; APB master and core strobes here
`timescale 1ns/1ps
module testbench;
  import cpu_state_pkg::*;

  localparam logic [9:0] S_PUSH  = 10'h001;
  localparam logic [9:0] S_PULL  = 10'h002;
  localparam logic [9:0] S_RSP   = 10'h004;
  localparam logic [9:0] S_FETCH = 10'h008;
  localparam logic [9:0] S_JUMP  = 10'h010;
  localparam logic [9:0] S_CLI   = 10'h020;
  localparam logic [9:0] S_RTI   = 10'h040;
  localparam logic [9:0] S_WAIT  = 10'h080;
  localparam logic [9:0] S_STOP  = 10'h100;
  localparam logic [9:0] S_LAST  = 10'h200;

  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [9:0]  stb = 10'h000;
  logic [15:0] JUMP_ADDR = 16'h0000;
  logic [15:0] SP_OFS = 16'h0000;
  logic        SP_OFS_WIDE = 1'b0;
  logic [7:0]  ALU_RESULT = 8'h00;
  logic        ALU_CARRY = 1'b0;
  logic        ALU_OVF = 1'b0;
  logic        ALU_HALF = 1'b0;
  logic [4:0]  FLAG_WE = 5'h00;
  logic [7:0]  PULL_DATA = 8'h00;
  logic [3:0]  IRQ_REQ = 4'h0;
  logic        BRK_REQ = 1'b0;
  logic        MONITOR = 1'b0;
  logic        VEC_VALID = 1'b0;
  logic [15:0] VEC_DATA = 16'h0000;
  logic [7:0]  ACC = 8'h00;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, VEC_RD, SWI_LOAD, BRK_ACTIVE;
  logic        CPU_CLK_EN, SIGNED_LT;
  logic [15:0] SP, PC, EA, VEC_ADDR, va;
  logic [7:0]  CONDITION_CODE_REG, DAA_ADJ;
  logic [1:0]  IRQ_ID;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n;

  always #50 CLK = ~CLK;

  cpu_state_regs dut_u (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PUSH_EN(stb[0]), .PULL_EN(stb[1]), .RSP_EN(stb[2]),
    .FETCH_EN(stb[3]), .JUMP_EN(stb[4]), .JUMP_ADDR(JUMP_ADDR),
    .SP_OFS(SP_OFS), .SP_OFS_WIDE(SP_OFS_WIDE), .ALU_RESULT(ALU_RESULT),
    .ALU_CARRY(ALU_CARRY), .ALU_OVF(ALU_OVF), .ALU_HALF(ALU_HALF),
    .FLAG_WE(FLAG_WE), .ACC(ACC), .CLI_EN(stb[5]), .RTI_CCR_EN(stb[6]),
    .PULL_DATA(PULL_DATA), .INSTR_LAST(stb[9]), .IRQ_REQ(IRQ_REQ),
    .WAIT_EN(stb[7]), .STOP_EN(stb[8]), .BRK_REQ(BRK_REQ),
    .MONITOR(MONITOR), .VEC_VALID(VEC_VALID), .VEC_DATA(VEC_DATA),
    .SP(SP), .PC(PC), .CONDITION_CODE_REG(CONDITION_CODE_REG), .EA(EA), .VEC_ADDR(VEC_ADDR),
    .VEC_RD(VEC_RD), .IRQ_ID(IRQ_ID), .SWI_LOAD(SWI_LOAD),
    .BRK_ACTIVE(BRK_ACTIVE), .CPU_CLK_EN(CPU_CLK_EN),
    .SIGNED_LT(SIGNED_LT), .DAA_ADJ(DAA_ADJ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic results();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd      = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic strobe(input logic [9:0] m);
    @(posedge CLK);
    stb <= m;
    @(posedge CLK);
    stb <= 10'h000;
    @(posedge CLK);
  endtask

  task automatic vec_serve(input logic [15:0] d);
    @(posedge CLK);
    VEC_DATA  <= d;
    VEC_VALID <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (VEC_RD !== 1'b1 && n < 5000);
    va = VEC_ADDR;
    if (n >= 5000) n_mismatch++;
    VEC_VALID <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic alu(input logic [7:0] r, input logic c, input logic v,
                     input logic h, input logic [4:0] we);
    @(posedge CLK);
    ALU_RESULT <= r;
    ALU_CARRY  <= c;
    ALU_OVF    <= v;
    ALU_HALF   <= h;
    FLAG_WE    <= we;
    @(posedge CLK);
    FLAG_WE    <= 5'h00;
    @(posedge CLK);
    @(posedge CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(20000 * 100);
    n_mismatch++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge CLK);
    chk(SP, SP_RST);
    chk(CONDITION_CODE_REG, CCR_RST);
    @(posedge CLK);
    RST <= 1'b0;
    vec_serve(16'h1234);
    chk(va, VEC_RESET);
    chk(PC, 16'h1234);
    apb(1'b0, OFS_SP, 32'h0);
    chk(rd, 32'h0000_00FF);
    apb(1'b1, OFS_CCR, 32'h0);
    apb(1'b0, OFS_CCR, 32'h0);
    chk(rd, 32'h0000_0060);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, OFS_SP, 32'h1234);
    strobe(S_RSP);
    chk(SP, 16'h12FF);
    strobe(S_PUSH);
    chk(SP, 16'h12FE);
    strobe(S_PULL);
    chk(SP, 16'h12FF);
    for (int w = 0; w < 2; w++) begin
      @(posedge CLK);
      SP_OFS      <= 16'h0180;
      SP_OFS_WIDE <= w[0];
      repeat (3) @(posedge CLK);
      chk(EA, w ? 16'h147F : 16'h137F);
    end
    strobe(S_FETCH);
    chk(PC, 16'h1235);
    JUMP_ADDR <= 16'h4000;
    strobe(S_FETCH | S_JUMP);
    chk(PC, 16'h4000);
    alu(8'h80, 1'b1, 1'b0, 1'b1, 5'h1F);
    chk(CONDITION_CODE_REG, 8'h75);
    chk(SIGNED_LT, 1'b1);
    chk(DAA_ADJ, 8'h66);
    alu(8'h00, 1'b0, 1'b1, 1'b0, 5'h12);
    chk(CONDITION_CODE_REG, 8'hF7);
    chk(SIGNED_LT, 1'b0);
    apb(1'b1, OFS_CCR, 32'h08);
    ACC     <= 8'hA5;
    IRQ_REQ <= 4'h1;
    strobe(S_LAST);
    repeat (11) @(posedge CLK);
    chk(SP, 16'h12FF);
    chk(DAA_ADJ, 8'h60);
    strobe(S_CLI);
    chk(CONDITION_CODE_REG[CCR_I], 1'b0);
    IRQ_REQ <= 4'h6;
    strobe(S_LAST);
    vec_serve(16'h5000);
    chk(va, 16'hFFF8);
    chk(IRQ_ID, 2'h1);
    chk(SP, 16'h12FA);
    chk(CONDITION_CODE_REG, 8'h68);
    chk(PC, 16'h5000);
    IRQ_REQ <= 4'h0;
    strobe(S_RTI);
    chk(CONDITION_CODE_REG, 8'h60);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFS_CCR, 32'h08);
      strobe(k ? S_STOP : S_WAIT);
      chk(CPU_CLK_EN, 1'b0);
      chk(CONDITION_CODE_REG[CCR_I], 1'b0);
      IRQ_REQ <= k ? 4'h1 : 4'h8;
      vec_serve(16'h6000);
      chk(va, k ? 16'hFFFA : 16'hFFF4);
      chk(k ? n > STAB_CYCLES : n < 20, 1'b1);
      chk(CPU_CLK_EN, 1'b1);
      IRQ_REQ <= 4'h0;
    end
    for (int m = 0; m < 2; m++) begin
      BRK_REQ <= 1'b1;
      MONITOR <= m[0];
      strobe(S_LAST);
      chk(SWI_LOAD, 1'b1);
      chk(BRK_ACTIVE, 1'b1);
      vec_serve(16'h7000);
      chk(va, m ? VEC_BRK_MON : VEC_BRK);
      strobe(S_RTI);
      chk(BRK_ACTIVE, 1'b1);
      BRK_REQ <= 1'b0;
      strobe(S_RTI);
      chk(BRK_ACTIVE, 1'b0);
    end
    results();
  end
endmodule
